// file: src/pc_bus_glue_pkg.sv
`default_nettype none
package pc_bus_glue_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int HOST_ADDR_W = 20;
  localparam int DEC_ADDR_W  = 18;
  localparam int DEC_LSB     = 2;
  localparam int GFX_ADDR_W  = 2;
  localparam int IRQ_LINES   = 3;

  // ----------------------------------------
  // decode windows on address bits 19..2
  // ----------------------------------------
  localparam logic [17:0] ROM_BASE = 18'h3_0000;
  localparam logic [17:0] ROM_MASK = 18'h3_e000;
  localparam logic [17:0] GFX_BASE = 18'h0_00c0;
  localparam logic [17:0] GFX_MASK = 18'h3_ffff;
  localparam logic [17:0] LUT_BASE = 18'h0_00c1;
  localparam logic [17:0] LUT_MASK = 18'h3_ffff;
  localparam logic [17:0] AUX_BASE = 18'h0_00c2;
  localparam logic [17:0] AUX_MASK = 18'h3_ffff;

  // ----------------------------------------
  // interrupt jumper positions
  // ----------------------------------------
  localparam int IRQ2_IDX = 0;
  localparam int IRQ3_IDX = 1;
  localparam int IRQ5_IDX = 2;

  // ----------------------------------------
  // timing figures
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int RD_VALID_NS    = 100;
  localparam int RD_BUS_NS      = 20;
  localparam int RD_VALID_CYC   = RD_VALID_NS / CLK_PERIOD_NS;
  localparam int RD_BUS_CYC     = RD_BUS_NS / CLK_PERIOD_NS;
  localparam int CONTROLLER_SYSTEM_CLOCK_DIV     = 2;
  localparam logic [GFX_ADDR_W-1:0] GFX_ADDR_DMA = 2'h0;
endpackage : pc_bus_glue_pkg
`default_nettype wire

// file: src/pc_bus_host_glue.sv
`timescale 1ns/1ps
`default_nettype none
module pc_bus_host_glue
  import pc_bus_glue_pkg::*;
#(
  parameter int IRQ_SEL = IRQ5_IDX
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_b_i,
  input  wire logic [HOST_ADDR_W-1:0] host_addr_i,
  input  wire logic                   aen_i,
  input  wire logic                   ale_i,
  input  wire logic                   ior_n_i,
  input  wire logic                   iow_n_i,
  input  wire logic                   memr_n_i,
  input  wire logic                   memw_n_i,
  input  wire logic                   sbhe_n_i,
  input  wire logic                   dack_n_i,
  input  wire logic                   bus16_i,
  input  wire logic                   gfx_int_i,
  output logic [HOST_ADDR_W-1:0]      board_address_bits_o,
  output logic                        gfx_chip_select_n_o,
  output logic                        gfx_read_strobe_n_o,
  output logic                        gfx_write_strobe_n_o,
  output logic [GFX_ADDR_W-1:0]       gfx_addr_o,
  output logic                        gfx_aen_n_o,
  output logic                        gfx_ale_n_o,
  output logic                        high_byte_buffer_en_n_o,
  output logic                        low_byte_buffer_en_n_o,
  output logic                        swap_byte_buffer_en_n_o,
  output logic                        buffer_to_host_o,
  output logic                        rom_left_en_n_o,
  output logic                        rom_right_en_n_o,
  output logic                        palette_rd_n_o,
  output logic                        palette_wr_n_o,
  output logic                        aux_reg_wr_n_o,
  output logic                        controller_system_clock_o,
  output logic                        buffered_interrupt_o,
  output logic [IRQ_LINES-1:0]        host_irq_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // masked compare of the decoded address field
  function automatic logic addr_hit(
    input logic [DEC_ADDR_W-1:0] a,
    input logic [DEC_ADDR_W-1:0] base,
    input logic [DEC_ADDR_W-1:0] mask
  );
    addr_hit = ((a ^ base) & mask) == '0;
  endfunction : addr_hit

  // ----------------------------------------
  // address buffer and decoder
  // ----------------------------------------
  logic [DEC_ADDR_W-1:0] dec_addr;
  logic                  boot_rom_match_n;
  logic                  gfx_select_match_n;
  logic                  lookup_table_match_n;
  logic                  aux_match_n;
  logic                  io_cycle;
  logic                  dma_act;
  logic                  a0;

  // buffered address feeds every decode term
  assign board_address_bits_o = host_addr_i;
  assign dec_addr = board_address_bits_o[HOST_ADDR_W-1:DEC_LSB];
  assign a0       = board_address_bits_o[0];
  // aen high marks a dma cycle, so io decode is blocked then
  assign io_cycle = ~aen_i;
  assign dma_act  = ~dack_n_i;

  // four active-low match terms
  always_comb begin
    boot_rom_match_n     = ~addr_hit(dec_addr, ROM_BASE, ROM_MASK);
    gfx_select_match_n   = ~(io_cycle & addr_hit(dec_addr, GFX_BASE, GFX_MASK));
    lookup_table_match_n = ~(io_cycle & addr_hit(dec_addr, LUT_BASE, LUT_MASK));
    aux_match_n          = ~(io_cycle & addr_hit(dec_addr, AUX_BASE, AUX_MASK));
  end

  // ----------------------------------------
  // io control decoder
  // ----------------------------------------
  logic gfx_sel;
  logic gfx_xfer;
  logic lut_xfer;
  logic aux_xfer;
  logic rom_cyc;
  logic io_strobe;

  // dma acknowledge fakes a controller select with address zero
  assign gfx_sel   = ~gfx_select_match_n | dma_act;
  assign io_strobe = ~ior_n_i | ~iow_n_i;
  assign gfx_xfer  = gfx_sel & io_strobe;
  assign lut_xfer  = ~lookup_table_match_n & io_strobe;
  assign aux_xfer  = ~aux_match_n & io_strobe;
  assign rom_cyc   = ~boot_rom_match_n & ~memr_n_i & ~aen_i;

  // controller controls: no clocked stage, so they track the bus strobes
  always_comb begin
    gfx_chip_select_n_o  = ~gfx_sel;
    gfx_read_strobe_n_o  = ~(gfx_sel & ~dma_act & ~ior_n_i);
    gfx_write_strobe_n_o = ~(gfx_sel & ~iow_n_i);
    gfx_addr_o           = dma_act ? GFX_ADDR_DMA : host_addr_i[GFX_ADDR_W-1:0];
    gfx_aen_n_o          = dma_act ? 1'b0 : aen_i;
    gfx_ale_n_o          = dma_act ? 1'b0 : ~ale_i;
    palette_rd_n_o       = ~(~lookup_table_match_n & ~ior_n_i);
    palette_wr_n_o       = ~(~lookup_table_match_n & ~iow_n_i);
    aux_reg_wr_n_o       = ~(~aux_match_n & ~iow_n_i);
  end

  // ----------------------------------------
  // buffer control decoder
  // ----------------------------------------
  // eight-bit mode picks one rom by a0; sixteen-bit mode opens both
  always_comb begin
    rom_left_en_n_o  = ~(rom_cyc & (bus16_i | a0));
    rom_right_en_n_o = ~(rom_cyc & (bus16_i | ~a0));
  end

  // buffers open only while a strobe is active, so they fall with it
  always_comb begin
    low_byte_buffer_en_n_o  = ~(gfx_xfer | lut_xfer | aux_xfer
                                | (rom_cyc & (bus16_i | ~a0)));
    high_byte_buffer_en_n_o = ~(bus16_i & (gfx_xfer | rom_cyc));
    swap_byte_buffer_en_n_o = ~(~bus16_i & rom_cyc & a0);
    buffer_to_host_o        = ~ior_n_i | ~memr_n_i;
  end

  // ----------------------------------------
  // controller clock divider
  // ----------------------------------------
  // toggling every rising edge of the 2x oscillator gives a 50 percent duty
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      controller_system_clock_o <= 1'b0;
    end else begin
      controller_system_clock_o <= ~controller_system_clock_o;
    end
  end

  // ----------------------------------------
  // interrupt buffer and jumper
  // ----------------------------------------
  // two flop stages; a jumper-like parameter picks the single line
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      buffered_interrupt_o <= 1'b0;
    end else begin
      buffered_interrupt_o <= gfx_int_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      host_irq_o <= '0;
    end else begin
      host_irq_o          <= '0;
      host_irq_o[IRQ_SEL] <= buffered_interrupt_o;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  property p_high_off_8bit;
    !bus16_i |-> high_byte_buffer_en_n_o;
  endproperty
  a_high_off_8bit: assert property (p_high_off_8bit)
    else $error("high buffer enabled on 8-bit backplane");

  property p_swap_odd_rom;
    (!bus16_i && rom_cyc && a0) |-> !swap_byte_buffer_en_n_o && !rom_left_en_n_o && rom_right_en_n_o;
  endproperty
  a_swap_odd_rom: assert property (p_swap_odd_rom)
    else $error("odd rom byte not routed through swap buffer");

  property p_wide_gfx;
    (bus16_i && gfx_xfer) |-> !high_byte_buffer_en_n_o && !low_byte_buffer_en_n_o;
  endproperty
  a_wide_gfx: assert property (p_wide_gfx)
    else $error("16-bit controller transfer not on both buffers");

  property p_clk_div;
    controller_system_clock_o |=> !controller_system_clock_o ##1 controller_system_clock_o;
  endproperty
  a_clk_div: assert property (p_clk_div)
    else $error("controller clock not divided by two");

  property p_irq_path;
    $rose(gfx_int_i) |=> buffered_interrupt_o ##1 host_irq_o[IRQ_SEL];
  endproperty
  a_irq_path: assert property (p_irq_path)
    else $error("interrupt not buffered to host line");

  property p_read_strobe;
    (!gfx_select_match_n && !dack_n_i == 1'b0) |->
      (gfx_read_strobe_n_o == ior_n_i) && (low_byte_buffer_en_n_o == !io_strobe);
  endproperty
  a_read_strobe: assert property (p_read_strobe)
    else $error("controller read strobe does not follow io read");

  property p_read_end;
    ($rose(ior_n_i) && iow_n_i && !gfx_select_match_n) |-> gfx_read_strobe_n_o && !gfx_chip_select_n_o;
  endproperty
  a_read_end: assert property (p_read_end)
    else $error("read strobe did not drop with io read");

  property p_write_end;
    ($rose(iow_n_i) && ior_n_i && gfx_sel) |-> gfx_write_strobe_n_o && low_byte_buffer_en_n_o;
  endproperty
  a_write_end: assert property (p_write_end)
    else $error("write strobe or buffer held after io write");

  property p_write_strobe;
    (gfx_sel && !iow_n_i) |-> !gfx_write_strobe_n_o && !low_byte_buffer_en_n_o;
  endproperty
  a_write_strobe: assert property (p_write_strobe)
    else $error("controller write strobe missing");

  property p_dma_force;
    !dack_n_i |-> !gfx_chip_select_n_o && gfx_addr_o == GFX_ADDR_DMA && !gfx_aen_n_o && !gfx_ale_n_o;
  endproperty
  a_dma_force: assert property (p_dma_force)
    else $error("dma acknowledge did not force controller write path");

  // zero-cycle path: the host side is open in the very cycle the read strobe is
  property p_rd_data_path;
    !gfx_read_strobe_n_o |-> buffer_to_host_o && !low_byte_buffer_en_n_o;
  endproperty
  a_rd_data_path: assert property (p_rd_data_path)
    else $error("read data path not open with controller read strobe");

  property p_irq_one_line;
    $onehot0(host_irq_o) && (host_irq_o == '0 || host_irq_o[IRQ_SEL]);
  endproperty
  a_irq_one_line: assert property (p_irq_one_line)
    else $error("interrupt reached a line other than the jumpered one");

  property p_irq_clear;
    !gfx_int_i |=> !buffered_interrupt_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("buffered interrupt held after controller interrupt fell");

  property p_low_all_8bit;
    (!bus16_i && (gfx_xfer || lut_xfer || aux_xfer)) |-> !low_byte_buffer_en_n_o && swap_byte_buffer_en_n_o;
  endproperty
  a_low_all_8bit: assert property (p_low_all_8bit)
    else $error("8-bit io transfer not on low buffer alone");

  property p_wide_rom;
    (bus16_i && rom_cyc) |-> !rom_left_en_n_o && !rom_right_en_n_o
      && !high_byte_buffer_en_n_o && !low_byte_buffer_en_n_o && swap_byte_buffer_en_n_o;
  endproperty
  a_wide_rom: assert property (p_wide_rom)
    else $error("16-bit rom read not sixteen bits wide");

  property p_select_on;
    !gfx_select_match_n |-> !gfx_chip_select_n_o;
  endproperty
  a_select_on: assert property (p_select_on)
    else $error("controller select missing while address matches");

  property p_select_off;
    (gfx_select_match_n && dack_n_i) |-> gfx_chip_select_n_o;
  endproperty
  a_select_off: assert property (p_select_off)
    else $error("controller select held after address moved");

  // a dma cycle owns the bus, so no io decode may answer it
  property p_aen_blocks;
    (aen_i && dack_n_i) |-> gfx_chip_select_n_o && palette_rd_n_o && palette_wr_n_o && aux_reg_wr_n_o;
  endproperty
  a_aen_blocks: assert property (p_aen_blocks)
    else $error("io decode answered during a dma cycle");

  property p_palette_wr;
    (!lookup_table_match_n && !iow_n_i && ior_n_i && dack_n_i) |->
      !palette_wr_n_o && palette_rd_n_o && gfx_write_strobe_n_o;
  endproperty
  a_palette_wr: assert property (p_palette_wr)
    else $error("palette write control wrong");

  property p_palette_rd;
    (!lookup_table_match_n && !ior_n_i && iow_n_i) |-> !palette_rd_n_o && palette_wr_n_o && buffer_to_host_o;
  endproperty
  a_palette_rd: assert property (p_palette_rd)
    else $error("palette read control wrong");

  property p_aux_wr;
    (!aux_match_n && !iow_n_i) |-> !aux_reg_wr_n_o && !low_byte_buffer_en_n_o;
  endproperty
  a_aux_wr: assert property (p_aux_wr)
    else $error("aux register write control missing");

  property p_rom_refused;
    (aen_i || memr_n_i) |-> rom_left_en_n_o && rom_right_en_n_o;
  endproperty
  a_rom_refused: assert property (p_rom_refused)
    else $error("rom enabled outside a host memory read");

  property p_dma_no_read;
    !dack_n_i |-> gfx_read_strobe_n_o;
  endproperty
  a_dma_no_read: assert property (p_dma_no_read)
    else $error("controller read strobe active during dma acknowledge");

  property p_addr_to_gfx;
    dack_n_i |-> gfx_addr_o == board_address_bits_o[GFX_ADDR_W-1:0];
  endproperty
  a_addr_to_gfx: assert property (p_addr_to_gfx)
    else $error("controller address not taken from board address lines");

endmodule : pc_bus_host_glue
`default_nettype wire

// file: verif/pc_bus_host_glue_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pc_bus_host_glue_tb import pc_bus_glue_pkg::*;;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  logic clock_i = 1'b0;
  logic rst_b_i, bus16_i, gfx_int_i, aen_i, ale_i, ior_n_i, iow_n_i, memr_n_i, memw_n_i, sbhe_n_i, dack_n_i;
  logic [HOST_ADDR_W-1:0] host_addr_i, board_address_bits_o;
  logic [GFX_ADDR_W-1:0] gfx_addr_o;
  logic [IRQ_LINES-1:0] host_irq_o;
  logic cs_n, rd_n, wr_n, hi_n, lo_n, sw_n, to_host, rl_n, rr_n, pr_n, pw_n, ax_n, aen_n, ale_n, sclk, buffered_interrupt, s;
  int bad_count = 0, check_count = 0, cyc = 0;
  // control outputs packed msb first so one compare covers a whole bus state
  wire logic [11:0] ctl = {cs_n, rd_n, wr_n, hi_n, lo_n, sw_n, to_host, rl_n, rr_n, pr_n, pw_n, ax_n};

  always #(CLK_PERIOD_NS / 2) clock_i = ~clock_i;

  pc_host_model u_pc_host_model (.clock_i(clock_i), .host_addr_o(host_addr_i), .aen_o(aen_i), .ale_o(ale_i),
    .ior_n_o(ior_n_i), .iow_n_o(iow_n_i), .memr_n_o(memr_n_i), .memw_n_o(memw_n_i), .sbhe_n_o(sbhe_n_i),
    .dack_n_o(dack_n_i));
  pc_bus_host_glue #(.IRQ_SEL(IRQ5_IDX)) u_pc_bus_host_glue (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .host_addr_i(host_addr_i), .aen_i(aen_i), .ale_i(ale_i),
    .ior_n_i(ior_n_i), .iow_n_i(iow_n_i), .memr_n_i(memr_n_i), .memw_n_i(memw_n_i), .sbhe_n_i(sbhe_n_i),
    .dack_n_i(dack_n_i), .bus16_i(bus16_i), .gfx_int_i(gfx_int_i), .board_address_bits_o(board_address_bits_o),
    .gfx_chip_select_n_o(cs_n), .gfx_read_strobe_n_o(rd_n), .gfx_write_strobe_n_o(wr_n), .gfx_addr_o(gfx_addr_o),
    .gfx_aen_n_o(aen_n), .gfx_ale_n_o(ale_n), .high_byte_buffer_en_n_o(hi_n), .low_byte_buffer_en_n_o(lo_n),
    .swap_byte_buffer_en_n_o(sw_n), .buffer_to_host_o(to_host), .rom_left_en_n_o(rl_n), .rom_right_en_n_o(rr_n),
    .palette_rd_n_o(pr_n), .palette_wr_n_o(pw_n), .aux_reg_wr_n_o(ax_n), .controller_system_clock_o(sclk),
    .buffered_interrupt_o(buffered_interrupt), .host_irq_o(host_irq_o));

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one host bus state, then judge the decode once it has settled
  task automatic step(input logic [19:0] a, input logic [5:0] c, input logic [11:0] exp);
    u_pc_host_model.bus_phase(a, c);
    #1;
    chk(board_address_bits_o, a);
    chk(20'(ctl), 20'(exp));
  endtask : step

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_io(input logic b16);
    @(posedge clock_i);
    bus16_i <= b16;
    step(20'h0_0303, 6'h1f, 12'h7df);
    chk(20'({gfx_addr_o, aen_n, ale_n}), 20'h0_000c);
    step(20'h0_0303, 6'h07, b16 ? 12'h27f : 12'h37f);
    step(20'h0_0303, 6'h0f, 12'h7df);
    step(20'h0_0000, 6'h0f, 12'hfdf);
    step(20'h0_0300, 6'h0f, 12'h7df);
    step(20'h0_0300, 6'h0b, b16 ? 12'h45f : 12'h55f);
    step(20'h0_0300, 6'h0f, 12'h7df);
    step(20'h0_0000, 6'h0f, 12'hfdf);
  endtask : t_io

  // odd rom bytes come through the swap path on a narrow bus, both roms on a wide one
  task automatic t_rom();
    @(posedge clock_i);
    bus16_i <= 1'b0;
    step(20'hc_0000, 6'h0d, 12'hf77);
    step(20'hc_0001, 6'h0d, 12'hfaf);
    @(posedge clock_i);
    bus16_i <= 1'b1;
    step(20'hc_0000, 6'h0d, 12'he67);
    step(20'h0_0000, 6'h0f, 12'hfdf);
  endtask : t_rom

  task automatic t_dev();
    @(posedge clock_i);
    bus16_i <= 1'b0;
    step(20'h0_0304, 6'h07, 12'hf7b);
    step(20'h0_0304, 6'h0b, 12'hf5d);
    step(20'h0_0308, 6'h0b, 12'hf5e);
    step(20'h0_0300, 6'h27, 12'hfff);
    step(20'h0_0000, 6'h0f, 12'hfdf);
  endtask : t_dev

  // a dma acknowledge must look like a controller write at address zero
  task automatic t_dma();
    @(posedge clock_i);
    bus16_i <= 1'b1;
    step(20'h0_0123, 6'h2a, 12'h45f);
    chk(20'({gfx_addr_o, aen_n, ale_n}), 20'h0_0000);
    u_pc_host_model.bus_phase(20'h0_0123, 6'h26);
    #1;
    chk(20'(rd_n), 20'h0_0001);
    step(20'h0_0000, 6'h0f, 12'hfdf);
  endtask : t_dma

  task automatic t_clk_irq();
    @(posedge clock_i);
    #1;
    s = sclk;
    chk(20'(sclk), 20'h0_0001);
    repeat (3) begin
      @(posedge clock_i);
      #1;
      chk(20'(sclk), 20'(!s));
      s = sclk;
    end
    // interrupt rises and falls on clock edges; each flop stage adds one cycle
    @(posedge clock_i);
    gfx_int_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk(20'({buffered_interrupt, host_irq_o}), 20'h0_0008);
    @(posedge clock_i);
    #1;
    chk(20'({buffered_interrupt, host_irq_o}), 20'h0_000c);
    @(posedge clock_i);
    gfx_int_i <= 1'b0;
    @(posedge clock_i);
    #1;
    chk(20'({buffered_interrupt, host_irq_o}), 20'h0_0004);
    @(posedge clock_i);
    #1;
    chk(20'({buffered_interrupt, host_irq_o}), 20'h0_0000);
  endtask : t_clk_irq

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // a hung handshake must not stall the run
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    rst_b_i = 1'b0;
    bus16_i = 1'b0;
    gfx_int_i = 1'b0;
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b1;
    #1;
    chk(20'({sclk, buffered_interrupt, host_irq_o}), 20'h0_0000);
    t_clk_irq();
    t_io(1'b0);
    t_io(1'b1);
    t_rom();
    t_dev();
    t_dma();
    conclude();
  end
endmodule : pc_bus_host_glue_tb
`default_nettype wire

// file: verif/pc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pc_host_model
  import pc_bus_glue_pkg::*;
(
  input  wire logic                   clock_i,
  output logic [HOST_ADDR_W-1:0]      host_addr_o,
  output logic                        aen_o,
  output logic                        ale_o,
  output logic                        ior_n_o,
  output logic                        iow_n_o,
  output logic                        memr_n_o,
  output logic                        memw_n_o,
  output logic                        sbhe_n_o,
  output logic                        dack_n_o
);
  // ----------------------------------------
  // host bus states
  // ----------------------------------------
  // idle bus; memory writes are never issued since the board decodes no memory writes
  initial begin
    {aen_o, ale_o, ior_n_o, iow_n_o, memr_n_o, dack_n_o} = 6'h0f;
    host_addr_o = '0;
    memw_n_o = 1'b1;
    sbhe_n_o = 1'b1;
  end

  // one bus state: change just after the edge, hold until the next state
  task automatic bus_phase(input logic [HOST_ADDR_W-1:0] a, input logic [5:0] c);
    @(posedge clock_i);
    host_addr_o <= a;
    {aen_o, ale_o, ior_n_o, iow_n_o, memr_n_o, dack_n_o} <= c;
  endtask : bus_phase
endmodule : pc_host_model
`default_nettype wire
